/* File: port_cell_pkg.sv */
// Shared constants for the port pin cell block: register map, resets, widths
package port_cell_pkg;

  // Pin counts: port 0 and port 1 are full bytes, port 2 holds one pin
  localparam int NPINS      = 17;
  localparam int NPINS_ANA  = 16;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int REG_W      = 8;

  // Byte addresses of the registers
  localparam logic [7:0] OFF_P0_DATA  = 8'h80;
  localparam logic [7:0] OFF_P1_DATA  = 8'h84;
  localparam logic [7:0] OFF_P2_DATA  = 8'h88;
  localparam logic [7:0] OFF_P0_KIND  = 8'h8C;
  localparam logic [7:0] OFF_P1_KIND  = 8'h90;
  localparam logic [7:0] OFF_P0_DRIVE = 8'h94;
  localparam logic [7:0] OFF_P1_DRIVE = 8'h98;
  localparam logic [7:0] OFF_P2_DRIVE = 8'h9C;
  localparam logic [7:0] OFF_P0_SKIP  = 8'hA0;
  localparam logic [7:0] OFF_P1_SKIP  = 8'hA4;
  localparam logic [7:0] OFF_P2_SKIP  = 8'hA8;
  localparam logic [7:0] OFF_CTRL     = 8'hAC;

  // Control register bit positions
  localparam int CTRL_XBAR_BIT  = 0;
  localparam int CTRL_PUOFF_BIT = 1;

  // Values after reset
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_KIND  = 8'hFF;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_SKIP  = 8'h00;
  localparam logic       RST_CTRL  = 1'b0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: pin_sync2.sv */
// Two-stage synchroniser for the pad input levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule
`default_nettype wire

/* File: pad_cell.sv */
// Drive, pull-up and receive logic of one port pin cell
`timescale 1ns/1ps
`default_nettype none
module pad_cell (
  // Configuration
  input  wire logic digital,
  input  wire logic push_pull,
  input  wire logic od_force,
  input  wire logic xbar_en,
  input  wire logic pu_off,
  // Data
  input  wire logic out_val,
  input  wire logic pad_lvl,
  // Cell controls
  output logic      drv_high,
  output logic      drv_low,
  output logic      pullup_on,
  output logic      rx_level
);

  logic drv_allow;

  // Drivers need a digital pin and an enabled crossbar
  assign drv_allow = xbar_en & digital;
  // High side only in push-pull, and never on forced bus pins
  assign drv_high  = drv_allow & push_pull & ~od_force & out_val;
  assign drv_low   = drv_allow & ~out_val;
  // Pull-up drops while pulling low or when disabled globally
  assign pullup_on = digital & ~drv_low & ~pu_off;
  // Receiver off for analog pins, so they read zero
  assign rx_level  = digital & pad_lvl;

endmodule
`default_nettype wire

/* File: port_io_cell_config.sv */
// Port pin cell configuration block with an AXI4-Lite register slave
//
// How it works
// - Reset leaves cells high-impedance, pull-ups on
// - No drivers until crossbar enable is 1
// - Analog pin: pull-up, driver, receiver disabled
// - Analog pin always reads back 0
// - Push-pull pin drives pad to output value
// - Open-drain: low on 0, high-impedance on 1
// - Pull-up on unless driving low or disabled
// - Digital pin reads actual pad level
// - Skip bit hides pin from crossbar
// - Crossbar never alters kind or drive settings
// - Bus clock and data pins forced open-drain
// - Port 0 data: resets ones, write latch, read pins
`timescale 1ns/1ps
`default_nettype none
module port_io_cell_config (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Crossbar side
  input  wire logic [16:0] periph_own,
  input  wire logic [16:0] periph_val,
  input  wire logic [16:0] smbus_pin,
  output logic      [16:0] pin_rx,
  // Pads
  input  wire logic [16:0] pad_in,
  output logic      [16:0] pad_out,
  output logic      [16:0] pad_oe,
  output logic      [16:0] pad_pullup
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state

  logic [16:0] latch_reg;
  logic [15:0] kind_reg;
  logic [16:0] drive_reg;
  logic [16:0] skip_reg;
  logic        xbar_en_reg;
  logic        pu_off_reg;

  // Bus handshake state
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  w_byte_reg;
  logic        w_strb_reg;

  // Pad side flops
  logic [16:0] pad_out_reg;
  logic [16:0] pad_oe_reg;
  logic [16:0] pad_pullup_reg;
  logic [16:0] pin_rx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel handshake

  logic        aw_fire;
  logic        w_fire;
  logic        do_write;
  logic        aw_have_next;
  logic        w_have_next;
  logic        bvalid_next;
  logic        awready_next;
  logic        wready_next;

  // Address and data may arrive in either order
  assign aw_fire      = awvalid & awready_reg;
  assign w_fire       = wvalid & wready_reg;
  assign do_write     = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign aw_have_next = (aw_have_reg | aw_fire) & ~do_write;
  assign w_have_next  = (w_have_reg | w_fire) & ~do_write;
  assign bvalid_next  = do_write | (bvalid_reg & ~bready);
  // Each channel is refused while its half is held or a response waits
  assign awready_next = ~aw_have_next & ~bvalid_next;
  assign wready_next  = ~w_have_next & ~bvalid_next;

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_byte_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      if (aw_fire) begin
        aw_addr_reg <= awaddr;
      end
      if (w_fire) begin
        w_byte_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic wr_p0_data;
  logic wr_p1_data;
  logic wr_p2_data;
  logic wr_p0_kind;
  logic wr_p1_kind;
  logic wr_p0_drive;
  logic wr_p1_drive;
  logic wr_p2_drive;
  logic wr_p0_skip;
  logic wr_p1_skip;
  logic wr_p2_skip;
  logic wr_ctrl;
  logic wr_hit;
  logic wr_en;

  // Only byte lane 0 carries register bits; others are ignored
  assign wr_en       = do_write & w_strb_reg;
  assign wr_p0_data  = aw_addr_reg == port_cell_pkg::OFF_P0_DATA;
  assign wr_p1_data  = aw_addr_reg == port_cell_pkg::OFF_P1_DATA;
  assign wr_p2_data  = aw_addr_reg == port_cell_pkg::OFF_P2_DATA;
  assign wr_p0_kind  = aw_addr_reg == port_cell_pkg::OFF_P0_KIND;
  assign wr_p1_kind  = aw_addr_reg == port_cell_pkg::OFF_P1_KIND;
  assign wr_p0_drive = aw_addr_reg == port_cell_pkg::OFF_P0_DRIVE;
  assign wr_p1_drive = aw_addr_reg == port_cell_pkg::OFF_P1_DRIVE;
  assign wr_p2_drive = aw_addr_reg == port_cell_pkg::OFF_P2_DRIVE;
  assign wr_p0_skip  = aw_addr_reg == port_cell_pkg::OFF_P0_SKIP;
  assign wr_p1_skip  = aw_addr_reg == port_cell_pkg::OFF_P1_SKIP;
  assign wr_p2_skip  = aw_addr_reg == port_cell_pkg::OFF_P2_SKIP;
  assign wr_ctrl     = aw_addr_reg == port_cell_pkg::OFF_CTRL;
  assign wr_hit      = wr_p0_data | wr_p1_data | wr_p2_data | wr_p0_kind
                     | wr_p1_kind | wr_p0_drive | wr_p1_drive | wr_p2_drive
                     | wr_p0_skip | wr_p1_skip | wr_p2_skip | wr_ctrl;

  // Output latches: writes set latch, never the pin reading
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= {port_cell_pkg::RST_LATCH[0],
                    port_cell_pkg::RST_LATCH,
                    port_cell_pkg::RST_LATCH};
    end else if (wr_en) begin
      if (wr_p0_data) begin
        latch_reg[7:0] <= w_byte_reg;
      end
      if (wr_p1_data) begin
        latch_reg[15:8] <= w_byte_reg;
      end
      if (wr_p2_data) begin
        latch_reg[16] <= w_byte_reg[0];
      end
    end
  end

  // Input kind: port 2 has none, it stays digital
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_reg <= {port_cell_pkg::RST_KIND, port_cell_pkg::RST_KIND};
    end else if (wr_en) begin
      if (wr_p0_kind) begin
        kind_reg[7:0] <= w_byte_reg;
      end
      if (wr_p1_kind) begin
        kind_reg[15:8] <= w_byte_reg;
      end
    end
  end

  // Drive style select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_reg <= {port_cell_pkg::RST_DRIVE[0],
                    port_cell_pkg::RST_DRIVE,
                    port_cell_pkg::RST_DRIVE};
    end else if (wr_en) begin
      if (wr_p0_drive) begin
        drive_reg[7:0] <= w_byte_reg;
      end
      if (wr_p1_drive) begin
        drive_reg[15:8] <= w_byte_reg;
      end
      if (wr_p2_drive) begin
        drive_reg[16] <= w_byte_reg[0];
      end
    end
  end

  // Crossbar skip select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_reg <= {port_cell_pkg::RST_SKIP[0],
                   port_cell_pkg::RST_SKIP,
                   port_cell_pkg::RST_SKIP};
    end else if (wr_en) begin
      if (wr_p0_skip) begin
        skip_reg[7:0] <= w_byte_reg;
      end
      if (wr_p1_skip) begin
        skip_reg[15:8] <= w_byte_reg;
      end
      if (wr_p2_skip) begin
        skip_reg[16] <= w_byte_reg[0];
      end
    end
  end

  // Global controls: crossbar enable and pull-up disable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xbar_en_reg <= port_cell_pkg::RST_CTRL;
      pu_off_reg  <= port_cell_pkg::RST_CTRL;
    end else if (wr_en && wr_ctrl) begin
      xbar_en_reg <= w_byte_reg[port_cell_pkg::CTRL_XBAR_BIT];
      pu_off_reg  <= w_byte_reg[port_cell_pkg::CTRL_PUOFF_BIT];
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= port_cell_pkg::RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_hit ? port_cell_pkg::RESP_OKAY
                            : port_cell_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin cells

  logic [16:0] pad_sync;
  logic [16:0] digital_vec;
  logic [16:0] owner_vec;
  logic [16:0] out_vec;
  logic [16:0] od_vec;
  logic [16:0] drv_high;
  logic [16:0] drv_low;
  logic [16:0] pullup_on;
  logic [16:0] rx_level;

  // Pad levels are asynchronous to aclk
  pin_sync2 #(
    .W        (port_cell_pkg::NPINS)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // Port 2 pin is digital only; kind and drive never follow the crossbar
  assign digital_vec = {1'b1, kind_reg};
  // A skipped pin is never handed to a peripheral
  assign owner_vec   = periph_own & ~skip_reg;
  assign out_vec     = (owner_vec & periph_val) | (~owner_vec & latch_reg);
  // Bus clock and data pins lose their high-side driver
  assign od_vec      = owner_vec & smbus_pin;

  // One cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < port_cell_pkg::NPINS; gi = gi + 1) begin : g_cell
      pad_cell u_cell (
        .digital   (digital_vec[gi]),
        .push_pull (drive_reg[gi]),
        .od_force  (od_vec[gi]),
        .xbar_en   (xbar_en_reg),
        .pu_off    (pu_off_reg),
        .out_val   (out_vec[gi]),
        .pad_lvl   (pad_sync[gi]),
        .drv_high  (drv_high[gi]),
        .drv_low   (drv_low[gi]),
        .pullup_on (pullup_on[gi]),
        .rx_level  (rx_level[gi])
      );
    end
  endgenerate

  // Pad controls registered, one cycle after configuration changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_reg    <= '0;
      pad_oe_reg     <= '0;
      pad_pullup_reg <= '1;
      pin_rx_reg     <= '0;
    end else begin
      pad_out_reg    <= drv_high;
      pad_oe_reg     <= drv_high | drv_low;
      pad_pullup_reg <= pullup_on;
      pin_rx_reg     <= rx_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic        ar_fire;
  logic        rvalid_next;
  logic        rd_hit;
  logic [7:0]  rd_byte;
  logic [7:0]  rd_ctrl;

  assign ar_fire     = arvalid & arready_reg;
  assign rvalid_next = ar_fire | (rvalid_reg & ~rready);
  assign rd_ctrl     = {6'h00, pu_off_reg, xbar_en_reg};

  // Data registers return pin levels, not latches
  assign rd_byte =
      (araddr == port_cell_pkg::OFF_P0_DATA)  ? rx_level[7:0]    :
      (araddr == port_cell_pkg::OFF_P1_DATA)  ? rx_level[15:8]   :
      (araddr == port_cell_pkg::OFF_P2_DATA)  ? {7'h00, rx_level[16]} :
      (araddr == port_cell_pkg::OFF_P0_KIND)  ? kind_reg[7:0]    :
      (araddr == port_cell_pkg::OFF_P1_KIND)  ? kind_reg[15:8]   :
      (araddr == port_cell_pkg::OFF_P0_DRIVE) ? drive_reg[7:0]   :
      (araddr == port_cell_pkg::OFF_P1_DRIVE) ? drive_reg[15:8]  :
      (araddr == port_cell_pkg::OFF_P2_DRIVE) ? {7'h00, drive_reg[16]} :
      (araddr == port_cell_pkg::OFF_P0_SKIP)  ? skip_reg[7:0]    :
      (araddr == port_cell_pkg::OFF_P1_SKIP)  ? skip_reg[15:8]   :
      (araddr == port_cell_pkg::OFF_P2_SKIP)  ? {7'h00, skip_reg[16]} :
      (araddr == port_cell_pkg::OFF_CTRL)     ? rd_ctrl          : 8'h00;

  assign rd_hit = (araddr == port_cell_pkg::OFF_P0_DATA)
                | (araddr == port_cell_pkg::OFF_P1_DATA)
                | (araddr == port_cell_pkg::OFF_P2_DATA)
                | (araddr == port_cell_pkg::OFF_P0_KIND)
                | (araddr == port_cell_pkg::OFF_P1_KIND)
                | (araddr == port_cell_pkg::OFF_P0_DRIVE)
                | (araddr == port_cell_pkg::OFF_P1_DRIVE)
                | (araddr == port_cell_pkg::OFF_P2_DRIVE)
                | (araddr == port_cell_pkg::OFF_P0_SKIP)
                | (araddr == port_cell_pkg::OFF_P1_SKIP)
                | (araddr == port_cell_pkg::OFF_P2_SKIP)
                | (araddr == port_cell_pkg::OFF_CTRL);

  // Read data captured at the address handshake; one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= port_cell_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_fire) begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_hit ? port_cell_pkg::RESP_OKAY
                            : port_cell_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign awready    = awready_reg;
  assign wready     = wready_reg;
  assign bvalid     = bvalid_reg;
  assign bresp      = bresp_reg;
  assign arready    = arready_reg;
  assign rvalid     = rvalid_reg;
  assign rresp      = rresp_reg;
  assign rdata      = rdata_reg;
  assign pad_out    = pad_out_reg;
  assign pad_oe     = pad_oe_reg;
  assign pad_pullup = pad_pullup_reg;
  assign pin_rx     = pin_rx_reg;

endmodule
`default_nettype wire

/* File: port_io_cell_config_props.sv */
// Checker for the port pin cell block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module port_io_cell_config_chk (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register bus
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  input  wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  input  wire logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  input  wire logic        rready,
  // Crossbar and pads
  input  wire logic [16:0] periph_own,
  input  wire logic [16:0] smbus_pin,
  input  wire logic [16:0] pin_rx,
  input  wire logic [16:0] pad_in,
  input  wire logic [16:0] pad_out,
  input  wire logic [16:0] pad_oe,
  input  wire logic [16:0] pad_pullup
);
  logic [7:0] aw_q;
  logic [8:0] w_q;
  logic       bv_q;
  logic [1:0] ctrl_sh;
  logic [2:0] up_cnt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the control register, taken when the write answer appears
  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_q <= awaddr;
    if (wvalid && wready) w_q <= {wstrb[0], wdata[7:0]};
  end
  // Updated one edge after the register, the same lag the pads have
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q    <= 1'b0;
      ctrl_sh <= 2'h0;
    end else begin
      bv_q <= bvalid;
      if (bvalid && !bv_q && bresp == port_cell_pkg::RESP_OKAY
          && aw_q == port_cell_pkg::OFF_CTRL && w_q[8])
        ctrl_sh <= w_q[1:0];
    end
  end
  // Cycles since reset release; synchroniser holds stale data before that
  always_ff @(posedge aclk) begin
    if (!aresetn) up_cnt <= 3'h0;
    else if (up_cnt != 3'h4) up_cnt <= up_cnt + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_RESET_HIZ: assert property (disable iff (1'b0) !aresetn |=>
    pad_oe == 17'h00000 && pad_pullup == 17'h1FFFF) else $error("cells not idle in reset");
  AST_XBAR_OFF_NO_DRIVE: assert property (!ctrl_sh[0] |-> pad_oe == 17'h00000)
    else $error("pad driven while crossbar off");
  AST_HIGH_NEEDS_OE: assert property ((pad_out & ~pad_oe) == 17'h00000)
    else $error("high level without drive");
  AST_LOW_NO_PULLUP: assert property ((pad_oe & ~pad_out & pad_pullup) == 17'h00000)
    else $error("pull-up on while driving low");
  AST_PU_GLOBAL_OFF: assert property (ctrl_sh[1] |-> pad_pullup == 17'h00000)
    else $error("pull-up on while globally off");
  AST_SMBUS_NO_HIGH: assert property (($past(periph_own & smbus_pin) & pad_out)
    == 17'h00000) else $error("bus line driven high");
  AST_P20_READS_PAD: assert property (up_cnt == 3'h4 |->
    pin_rx[16] == $past(pad_in[16], 3)) else $error("pin 16 receive level wrong");
  AST_WRITE_RESP: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  AST_READ_RESP: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_READ_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");

  CV_DRIVE: cover property (ctrl_sh[0] && pad_oe != 17'h00000);
  CV_BUS_LINE: cover property ((periph_own & smbus_pin) != 17'h00000);
  CV_PU_OFF: cover property (ctrl_sh[1]);
endmodule

bind port_io_cell_config port_io_cell_config_chk u_chk (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
  .bresp, .bvalid, .arvalid, .arready, .rdata, .rvalid, .rready, .periph_own,
  .smbus_pin, .pin_rx, .pad_in, .pad_out, .pad_oe, .pad_pullup
);
`default_nettype wire

/* File: pad_partner_model.sv */
// External circuitry on the pads: resolves each wire's level
`timescale 1ns/1ps
`default_nettype none
module pad_partner_model (
  // Clock
  input  wire logic        aclk,
  // Cell controls
  input  wire logic [16:0] pad_out,
  input  wire logic [16:0] pad_oe,
  input  wire logic [16:0] pad_pullup,
  // External source
  input  wire logic [16:0] ext_en,
  input  wire logic [16:0] ext_val,
  // Wire level
  output logic      [16:0] pad_in
);
  logic [16:0] float_reg = 17'h00000;

  // Unheld wires wander, so a stale level never passes for a drive
  always @(posedge aclk) float_reg <= ~float_reg;

  // Cell drive first, then outside source, then weak pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | float_reg));
endmodule
`default_nettype wire

/* File: tb_port_io_cell_config.sv */
// Self-checking testbench for the port pin cell block
`timescale 1ns/1ps
`default_nettype none
module tb_port_io_cell_config;
  localparam logic [1:0] OK_R  = port_cell_pkg::RESP_OKAY;
  localparam logic [1:0] ERR_R = port_cell_pkg::RESP_SLVERR;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [16:0] periph_own, periph_val, smbus_pin, pin_rx, ext_en, ext_val;
  logic [16:0] pad_in, pad_out, pad_oe, pad_pullup;
  int          fail_count = 0;
  int          checks = 0;
  logic [7:0]  ra [12] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C,
                          8'hA0, 8'hA4, 8'hA8, 8'hAC};
  logic [7:0]  rv [12] = '{8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h00, 8'h00};

  port_io_cell_config DUT (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .periph_own, .periph_val, .smbus_pin, .pin_rx, .pad_in,
    .pad_out, .pad_oe, .pad_pullup
  );
  pad_partner_model u_far (.aclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val,
    .pad_in);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_pins(input string nm, input logic [16:0] e, input logic [16:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    bit aw_d = 0;
    bit w_d = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      aw_d |= awready;
      w_d |= wready;
      awvalid <= !aw_d;
      wvalid <= !w_d;
    end
    do @(posedge aclk); while (!bvalid);
    cmp_word("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    // Ready a cycle late, so the answer must stand while unread
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    cmp_word("rdata", {24'h000000, d}, rdata);
    cmp_word("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end

  initial begin
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    {awvalid, wvalid, arvalid, rready} = '0;
    bready = 1'b1; // Held high, so back-to-back writes never toggle it
    {periph_own, periph_val, smbus_pin, ext_en, ext_val} = '0;
    wstrb = 4'h1;
    aresetn = 1'b0;
    tick(20);
    aresetn <= 1'b1;
    tick(2);
    cmp_pins("pad_oe", 17'h00000, pad_oe);
    cmp_pins("pad_pullup", 17'h1FFFF, pad_pullup);
    foreach (ra[i]) rd(ra[i], rv[i], OK_R);
    rd(8'hB0, 8'h00, ERR_R);
    wr(8'hB0, 8'h55, ERR_R);
    // Configured to drive, but crossbar still off
    wr(8'h94, 8'hFF, OK_R);
    wr(8'h80, 8'h00, OK_R);
    tick(2);
    cmp_pins("pad_oe", 17'h00000, pad_oe);
    wr(8'hAC, 8'h01, OK_R);
    tick(2);
    cmp_pins("pad_oe", 17'h000FF, pad_oe);
    cmp_pins("pad_pullup", 17'h1FF00, pad_pullup);
    wr(8'h80, 8'hA5, OK_R);
    tick(4);
    cmp_pins("pad_out", 17'h000A5, pad_out);
    cmp_pins("pad_pullup", 17'h1FFA5, pad_pullup);
    rd(8'h80, 8'hA5, OK_R);
    // Open drain with pin 0 pulled low from outside
    wr(8'h94, 8'h00, OK_R);
    ext_en <= 17'h00001;
    tick(4);
    cmp_pins("pad_oe", 17'h0005A, pad_oe);
    cmp_pins("pad_out", 17'h00000, pad_out);
    rd(8'h80, 8'hA4, OK_R);
    // Pin 0 analog, held high outside, latch low
    ext_val <= 17'h00001;
    wr(8'h8C, 8'hFE, OK_R);
    wr(8'h80, 8'hA4, OK_R);
    tick(4);
    cmp_pins("pad_oe", 17'h0005A, pad_oe);
    cmp_pins("pad_pullup", 17'h1FFA4, pad_pullup);
    cmp_pins("pin_rx", 17'h00000, pin_rx & 17'h00001);
    rd(8'h80, 8'hA4, OK_R);
    wr(8'h80, 8'hA5, OK_R);
    wr(8'h8C, 8'hFF, OK_R);
    ext_en <= 17'h00000;
    wr(8'hAC, 8'h03, OK_R);
    tick(2);
    cmp_pins("pad_pullup", 17'h00000, pad_pullup);
    wr(8'hAC, 8'h01, OK_R);
    // Port 1 push-pull; pins 8 and 9 owned, pin 9 a bus line
    wr(8'h98, 8'hFF, OK_R);
    periph_own <= 17'h00300;
    smbus_pin <= 17'h00200;
    tick(3);
    cmp_pins("pad_out", 17'h0FC00, pad_out);
    cmp_pins("pad_oe", 17'h0FF5A, pad_oe);
    periph_val <= 17'h00200;
    tick(3);
    cmp_pins("pad_oe", 17'h0FD5A, pad_oe);
    cmp_pins("pad_out", 17'h0FC00, pad_out);
    wr(8'hA4, 8'h01, OK_R);
    tick(2);
    cmp_pins("pad_out", 17'h0FD00, pad_out);
    rd(8'h90, 8'hFF, OK_R);
    rd(8'h98, 8'hFF, OK_R);
    // Pin 16 digital only
    wr(8'h9C, 8'h01, OK_R);
    wr(8'h88, 8'h00, OK_R);
    tick(4);
    cmp_pins("pad_oe", 17'h1FD5A, pad_oe);
    cmp_pins("pin_rx", 17'h00000, pin_rx & 17'h10000);
    rd(8'h88, 8'h00, OK_R);
    // Lane 0 strobe low: answered but ignored
    wstrb <= 4'h0;
    wr(8'hAC, 8'h00, OK_R);
    wstrb <= 4'h1;
    rd(8'hAC, 8'h01, OK_R);
    // Reset in mid-run
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    cmp_pins("pad_oe", 17'h00000, pad_oe);
    rd(8'hAC, 8'h00, OK_R);
    wrap_up();
  end
endmodule
`default_nettype wire
